/* rtl/grpsc_ctrl.sv */
// graphics rail power state controller top with register port
// Function
// - after reset the rail starts in full power, continuous conduction.
// - an accepted power-state command changes the state on the next edge.
// - light load means single phase with diode emulation, driver may tri-state.
// - a set-voltage-id command forces the rail back to full power.
// - after reaching target the rail stays full power, old request forgotten.
// - pin offset enable is caught once after reset and then held.
// - after the first valid vid the offset-select sink current turns on.
// - with pin offset on, bus offset added only when select pin above 1 V.
// - dac target above 1.2 V selects the pseudo constant frequency on-time.
// - with the rail disabled every bus command for it is rejected.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module grpsc_ctrl (
	input  wire logic       clk_sys_i,
	input  wire logic       arst_n_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output var  logic [7:0] rdata_o,
	input  wire logic       rail_disable_i,
	input  wire logic       pin_offset_grounded_i,
	input  wire logic       offset_select_above_i,
	output var  logic       diode_emul_en_o,
	output var  logic       single_phase_o,
	output var  logic       pcf_mode_o,
	output var  logic [7:0] dac_code_o,
	output var  logic [7:0] serial_voltage_id_bus_offset_o,
	output var  logic       serial_voltage_id_bus_offset_add_o,
	output var  logic       pin_offset_en_o,
	output var  logic       sink_current_en_o
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [grpsc_pkg::PIN_COUNT-1:0] pin_raw;
	logic [grpsc_pkg::PIN_COUNT-1:0] pin_meta;
	logic [grpsc_pkg::PIN_COUNT-1:0] pin_sync;

	assign pin_raw[grpsc_pkg::PIN_DISABLE]   = rail_disable_i;
	assign pin_raw[grpsc_pkg::PIN_GROUNDED]  = pin_offset_grounded_i;
	assign pin_raw[grpsc_pkg::PIN_SEL_ABOVE] = offset_select_above_i;

	// comparator outputs are asynchronous to the clock
	for (genvar i = 0; i < grpsc_pkg::PIN_COUNT; i++) begin : g_sync
		always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				pin_meta[i] <= 1'b0;
				pin_sync[i] <= 1'b0;
			end else begin
				pin_meta[i] <= pin_raw[i];
				pin_sync[i] <= pin_meta[i];
			end
		end
	end

	logic rail_dis;
	assign rail_dis = pin_sync[grpsc_pkg::PIN_DISABLE];

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic cmd_wr;
	logic vid_acc;
	logic ps_acc;
	logic ofs_acc;
	logic ps_code_ok;
	logic reject;
	logic stat_clr;

	assign cmd_wr     = wr_i && (addr_i == grpsc_pkg::ADDR_VID || addr_i == grpsc_pkg::ADDR_PS ||
	                             addr_i == grpsc_pkg::ADDR_OFS);
	assign ps_code_ok = (wdata_i == grpsc_pkg::PS_FULL_CODE) || (wdata_i == grpsc_pkg::PS_LIGHT_CODE);
	assign vid_acc    = wr_i && !rail_dis && addr_i == grpsc_pkg::ADDR_VID;
	assign ps_acc     = wr_i && !rail_dis && addr_i == grpsc_pkg::ADDR_PS && ps_code_ok;
	assign ofs_acc    = wr_i && !rail_dis && addr_i == grpsc_pkg::ADDR_OFS;
	// unsupported power-state codes are refused like a disabled rail
	assign reject     = (cmd_wr && rail_dis) ||
	                    (wr_i && !rail_dis && addr_i == grpsc_pkg::ADDR_PS && !ps_code_ok);
	assign stat_clr   = wr_i && addr_i == grpsc_pkg::ADDR_STAT && wdata_i[grpsc_pkg::ST_REJECT];

	// ------------------------------------------------------------
	// vid and offset units
	// ------------------------------------------------------------
	grpsc_vid_if vid ();

	assign vid.load   = vid_acc;
	assign vid.target = wdata_i;

	grpsc_vid_slew u_slew (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.vid       (vid.slew)
	);

	grpsc_ofs_sel u_ofs (
		.clk_sys_i    (clk_sys_i),
		.arst_n_i     (arst_n_i),
		.vid          (vid.ofs),
		.grounded_i   (pin_sync[grpsc_pkg::PIN_GROUNDED]),
		.sel_above_i  (pin_sync[grpsc_pkg::PIN_SEL_ABOVE]),
		.pin_ofs_en_o (pin_offset_en_o),
		.sink_en_o    (sink_current_en_o),
		.add_serial_voltage_id_bus_o   (serial_voltage_id_bus_offset_add_o)
	);

	// ------------------------------------------------------------
	// power state
	// ------------------------------------------------------------
	grpsc_pkg::grpsc_ps_type ps_state;
	grpsc_pkg::grpsc_ps_type next_ps_state;

	always_comb begin
		next_ps_state = ps_state;
		if (vid_acc) begin
			next_ps_state = grpsc_pkg::full_power_state;
		end else if (ps_acc) begin
			next_ps_state = (wdata_i == grpsc_pkg::PS_LIGHT_CODE) ? grpsc_pkg::light_load_state
			                                                       : grpsc_pkg::full_power_state;
		end
	end

	// light load is only re-entered by a fresh command, never by reaching target
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ps_state <= grpsc_pkg::full_power_state;
		end else begin
			ps_state <= next_ps_state;
		end
	end

	// driver outputs follow the state bit one cycle later
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			diode_emul_en_o <= 1'b0;
			single_phase_o  <= 1'b0;
		end else begin
			diode_emul_en_o <= (ps_state == grpsc_pkg::light_load_state);
			single_phase_o  <= (ps_state == grpsc_pkg::light_load_state);
		end
	end

	// ------------------------------------------------------------
	// dac, on-time regime and bus offset
	// ------------------------------------------------------------
	logic [7:0] ofs_code;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ofs_code <= grpsc_pkg::OFS_RESET;
		end else if (ofs_acc) begin
			ofs_code <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dac_code_o    <= grpsc_pkg::VID_RESET;
			pcf_mode_o    <= 1'b0;
			serial_voltage_id_bus_offset_o <= grpsc_pkg::OFS_RESET;
		end else begin
			dac_code_o    <= vid.dac;
			pcf_mode_o    <= (vid.dac > grpsc_pkg::DAC_PCF_THRESH);
			serial_voltage_id_bus_offset_o <= serial_voltage_id_bus_offset_add_o ? ofs_code : grpsc_pkg::OFS_RESET;
		end
	end

	// ------------------------------------------------------------
	// status and read port
	// ------------------------------------------------------------
	logic       reject_flag;
	logic [7:0] stat;

	// a reject in the clearing cycle keeps the flag set
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reject_flag <= 1'b0;
		end else if (reject) begin
			reject_flag <= 1'b1;
		end else if (stat_clr) begin
			reject_flag <= 1'b0;
		end
	end

	always_comb begin
		stat                          = 8'h00;
		stat[grpsc_pkg::ST_LIGHT]     = (ps_state == grpsc_pkg::light_load_state);
		stat[grpsc_pkg::ST_RAIL_EN]   = !rail_dis;
		stat[grpsc_pkg::ST_REACHED]   = vid.reached;
		stat[grpsc_pkg::ST_FIRST_VID] = vid.first_valid;
		stat[grpsc_pkg::ST_PIN_OFS]   = pin_offset_en_o;
		stat[grpsc_pkg::ST_ADD_SERIAL_VOLTAGE_ID_BUS]  = serial_voltage_id_bus_offset_add_o;
		stat[grpsc_pkg::ST_PCF]       = pcf_mode_o;
		stat[grpsc_pkg::ST_REJECT]    = reject_flag;
	end

	logic vid_tgt_wr;
	logic [7:0] vid_tgt;
	assign vid_tgt_wr = vid_acc;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vid_tgt <= grpsc_pkg::VID_RESET;
		end else if (vid_tgt_wr) begin
			vid_tgt <= wdata_i;
		end
	end

	// data stands one cycle only, zero otherwise and for unmapped addresses
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i)
				grpsc_pkg::ADDR_VID:  rdata_o <= vid_tgt;
				grpsc_pkg::ADDR_PS:   rdata_o <= (ps_state == grpsc_pkg::light_load_state) ?
				                                 grpsc_pkg::PS_LIGHT_CODE : grpsc_pkg::PS_FULL_CODE;
				grpsc_pkg::ADDR_OFS:  rdata_o <= ofs_code;
				grpsc_pkg::ADDR_STAT: rdata_o <= stat;
				default:              rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	logic any_ps_cmd;
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			any_ps_cmd <= 1'b0;
		end else if (ps_acc) begin
			any_ps_cmd <= 1'b1;
		end
	end

	a_reset_full_power: assert property (
		!any_ps_cmd |-> ps_state == grpsc_pkg::full_power_state && !diode_emul_en_o)
		else $error("left full power before any power-state command");
	a_ps_immediate: assert property (
		ps_acc && wdata_i == grpsc_pkg::PS_LIGHT_CODE |=> ps_state == grpsc_pkg::light_load_state)
		else $error("power-state command not applied next cycle");
	a_light_outputs: assert property (
		ps_state == grpsc_pkg::light_load_state |=> diode_emul_en_o && single_phase_o)
		else $error("light load without diode emulation and single phase");
	a_vid_exits_light: assert property (
		vid_acc |=> ps_state == grpsc_pkg::full_power_state ##1 !diode_emul_en_o)
		else $error("set-voltage-id did not return to full power");
	a_full_holds: assert property (
		ps_state == grpsc_pkg::full_power_state && !(ps_acc && wdata_i == grpsc_pkg::PS_LIGHT_CODE)
		|=> ps_state == grpsc_pkg::full_power_state)
		else $error("light load entered without a command");
	a_rail_reject: assert property (
		cmd_wr && rail_dis |=> $stable(ps_state) && reject_flag && $stable(ofs_code))
		else $error("command for disabled rail took effect");
	a_pcf_threshold: assert property (
		vid.dac > grpsc_pkg::DAC_PCF_THRESH ##1 vid.dac > grpsc_pkg::DAC_PCF_THRESH |-> pcf_mode_o)
		else $error("pseudo constant frequency not selected above threshold");
	a_phase_one_bit: assert property (
		diode_emul_en_o == single_phase_o)
		else $error("diode emulation and phase count disagree");

	c_enter_light: cover property (ps_acc && wdata_i == grpsc_pkg::PS_LIGHT_CODE ##1
		ps_state == grpsc_pkg::light_load_state);
	c_vid_from_light: cover property (ps_state == grpsc_pkg::light_load_state && vid_acc);
	c_reject: cover property (cmd_wr && rail_dis);
	c_pcf_on: cover property ($rose(pcf_mode_o));

	// output-level views and sticky behaviour
	a_reject_sticky: assert property (
		reject |=> reject_flag)
		else $error("reject lost to a same-cycle clear");
	a_reject_no_vid: assert property (
		cmd_wr && rail_dis |=> $stable(vid_tgt) && $stable(vid.first_valid))
		else $error("voltage-id taken while rail disabled");
	a_ps_to_full: assert property (
		ps_acc && wdata_i == grpsc_pkg::PS_FULL_CODE |=> ps_state == grpsc_pkg::full_power_state)
		else $error("full power command not applied next cycle");
	a_pcf_outputs: assert property (
		pcf_mode_o == (dac_code_o > grpsc_pkg::DAC_PCF_THRESH))
		else $error("on-time regime disagrees with dac code");
	a_dac_follows: assert property (
		dac_code_o == $past(vid.dac))
		else $error("dac output does not follow the stepper");
	a_offset_gated: assert property (
		!$past(serial_voltage_id_bus_offset_add_o) |-> serial_voltage_id_bus_offset_o == grpsc_pkg::OFS_RESET)
		else $error("bus offset driven while not added");
	a_sink_sticky: assert property (
		sink_current_en_o |=> sink_current_en_o)
		else $error("sink current dropped after being enabled");
	c_light_again: cover property (vid_acc ##[1:400] ps_acc &&
		wdata_i == grpsc_pkg::PS_LIGHT_CODE);

endmodule
`default_nettype wire

/* rtl/grpsc_pkg.sv */
// constants and types shared by the graphics rail power state control
package grpsc_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 5;
	localparam int unsigned VID_STEP_NS    = 500;
	localparam int unsigned VID_STEP_CYC   = VID_STEP_NS / CLK_PERIOD_NS;
	localparam logic [6:0]  VID_STEP_LAST  = 7'(VID_STEP_CYC - 1);
	localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0]  ADDR_VID       = 4'h0;
	localparam logic [3:0]  ADDR_PS        = 4'h1;
	localparam logic [3:0]  ADDR_OFS       = 4'h2;
	localparam logic [3:0]  ADDR_STAT      = 4'h3;
	localparam logic [7:0]  VID_RESET      = 8'h00;
	localparam logic [7:0]  OFS_RESET      = 8'h00;
	localparam logic [7:0]  PS_FULL_CODE   = 8'h00;
	localparam logic [7:0]  PS_LIGHT_CODE  = 8'h02;

	// status bit positions
	localparam int unsigned ST_LIGHT       = 0;
	localparam int unsigned ST_RAIL_EN     = 1;
	localparam int unsigned ST_REACHED     = 2;
	localparam int unsigned ST_FIRST_VID   = 3;
	localparam int unsigned ST_PIN_OFS     = 4;
	localparam int unsigned ST_ADD_SERIAL_VOLTAGE_ID_BUS    = 5;
	localparam int unsigned ST_PCF         = 6;
	localparam int unsigned ST_REJECT      = 7;

	// dac code for 1.2 V: 0.25 V at code 1, 5 mV per step
	localparam logic [7:0]  DAC_PCF_THRESH = 8'hbf;

	// pin synchroniser lanes
	localparam int unsigned PIN_DISABLE    = 0;
	localparam int unsigned PIN_GROUNDED   = 1;
	localparam int unsigned PIN_SEL_ABOVE  = 2;
	localparam int unsigned PIN_COUNT      = 3;

	typedef enum logic {
		full_power_state,
		light_load_state
	} grpsc_ps_type;

endpackage

/* rtl/grpsc_vid_if.sv */
// voltage-id carrier between the controller, slew unit and offset unit
`timescale 1ns/1ps
`default_nettype none
interface grpsc_vid_if;
	logic       load;
	logic [7:0] target;
	logic [7:0] dac;
	logic       reached;
	logic       first_valid;

	modport ctrl (output load, output target, input dac, input reached, input first_valid);
	modport slew (input load, input target, output dac, output reached, output first_valid);
	modport ofs  (input first_valid);
endinterface
`default_nettype wire

/* rtl/grpsc_vid_slew.sv */
// dac code stepper that walks the output toward the commanded vid
`timescale 1ns/1ps
`default_nettype none
module grpsc_vid_slew (
	input  wire logic clk_sys_i,
	input  wire logic arst_n_i,
	grpsc_vid_if.slew vid
);
	logic [6:0] step_cnt;
	logic       step_en;
	logic [7:0] tgt;

	// ------------------------------------------------------------
	// step enable divider
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			step_cnt <= 7'h00;
			step_en  <= 1'b0;
		end else begin
			step_en  <= (step_cnt == grpsc_pkg::VID_STEP_LAST);
			step_cnt <= (step_cnt == grpsc_pkg::VID_STEP_LAST) ? 7'h00 : step_cnt + 7'h01;
		end
	end

	// ------------------------------------------------------------
	// target and dac walk
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tgt             <= grpsc_pkg::VID_RESET;
			vid.first_valid <= 1'b0;
		end else if (vid.load) begin
			tgt             <= vid.target;
			vid.first_valid <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vid.dac <= grpsc_pkg::VID_RESET;
		end else if (step_en && vid.dac < tgt) begin
			vid.dac <= vid.dac + 8'h01;
		end else if (step_en && vid.dac > tgt) begin
			vid.dac <= vid.dac - 8'h01;
		end
	end

	// cleared by a new load so a stale match never reads as done
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vid.reached <= 1'b1;
		end else begin
			vid.reached <= (vid.dac == tgt) && !vid.load;
		end
	end

	a_dac_single_step: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!$past(step_en) |-> $stable(vid.dac))
		else $error("dac moved without a step enable");
endmodule
`default_nettype wire

/* rtl/grpsc_ofs_sel.sv */
// pin offset strap capture, sink current and bus offset selection
`timescale 1ns/1ps
`default_nettype none
module grpsc_ofs_sel (
	input  wire logic clk_sys_i,
	input  wire logic arst_n_i,
	grpsc_vid_if.ofs  vid,
	input  wire logic grounded_i,
	input  wire logic sel_above_i,
	output var  logic pin_ofs_en_o,
	output var  logic sink_en_o,
	output var  logic add_serial_voltage_id_bus_o
);
	logic [1:0] settle;
	logic       captured;

	// ------------------------------------------------------------
	// strap capture after the synchroniser has filled
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			settle       <= 2'h0;
			captured     <= 1'b0;
			pin_ofs_en_o <= 1'b0;
		end else if (!captured) begin
			settle <= settle + 2'h1;
			if (settle == grpsc_pkg::STRAP_SETTLE) begin
				captured     <= 1'b1;
				pin_ofs_en_o <= !grounded_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sink_en_o <= 1'b0;
		end else if (vid.first_valid) begin
			sink_en_o <= 1'b1;
		end
	end

	// once the strap is captured, with pin offset off the bus offset always applies
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			add_serial_voltage_id_bus_o <= 1'b0;
		end else begin
			add_serial_voltage_id_bus_o <= captured && (!pin_ofs_en_o || (sink_en_o && sel_above_i));
		end
	end

	a_strap_held: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		captured && $past(captured) |-> $stable(pin_ofs_en_o))
		else $error("pin offset enable changed after capture");
	a_sink_after_vid: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		$rose(vid.first_valid) |=> sink_en_o)
		else $error("sink current not on after first vid");
	a_ofs_below_sel: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		pin_ofs_en_o && !sel_above_i |=> !add_serial_voltage_id_bus_o)
		else $error("bus offset added below threshold");
endmodule
`default_nettype wire

/* sim/grpsc_cpu_model.sv */
// cpu-side register master issuing power-state and voltage-id commands
`timescale 1ns/1ps
`default_nettype none
module grpsc_cpu_model (
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] rdata_i,
	output var  logic [3:0] addr_o,
	output var  logic [7:0] wdata_o,
	output var  logic       wr_o,
	output var  logic       rd_o
);
	initial begin
		addr_o  = 4'h0;
		wdata_o = 8'h00;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
	end

	// released lines show a changed pattern, never the last value
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clk_sys_i);
		wr_o    <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clk_sys_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask

	// light load only comes back by a fresh power-state command after the vid
	task automatic light_after_vid(input logic [7:0] v);
		wr_reg(grpsc_pkg::ADDR_VID, v);
		wr_reg(grpsc_pkg::ADDR_PS, grpsc_pkg::PS_LIGHT_CODE);
	endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the graphics rail power state controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	logic       clk_sys_i;
	logic       arst_n_i;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       rail_dis;
	logic       grounded;
	logic       sel_above;
	logic       dem;
	logic       single;
	logic       pcf;
	logic [7:0] dac;
	logic [7:0] ofs;
	logic       ofs_add;
	logic       pin_en;
	logic       sink;
	logic [7:0] st;
	int         errors;
	int         total_checks;

	grpsc_ctrl i_grpsc_ctrl (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rail_disable_i(rail_dis),
		.pin_offset_grounded_i(grounded), .offset_select_above_i(sel_above),
		.diode_emul_en_o(dem), .single_phase_o(single), .pcf_mode_o(pcf),
		.dac_code_o(dac), .serial_voltage_id_bus_offset_o(ofs), .serial_voltage_id_bus_offset_add_o(ofs_add),
		.pin_offset_en_o(pin_en), .sink_current_en_o(sink)
	);

	grpsc_cpu_model i_cpu (
		.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd)
	);

	always #2.5 clk_sys_i = ~clk_sys_i;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic end_sim();
		if (errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// full slew from zero takes about 25500 cycles
	task automatic wait_dac(input logic [7:0] v);
		int n;
		n = 0;
		while (dac !== v && n < 25000) begin
			@(posedge clk_sys_i);
			n++;
		end
		@(negedge clk_sys_i);
		`CHK(dac, v)
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		@(negedge clk_sys_i);
		`CHK({dem, single, sink}, 3'b000)
		i_cpu.rd_reg(grpsc_pkg::ADDR_PS, st);
		`CHK(st, grpsc_pkg::PS_FULL_CODE)
		repeat (8) @(posedge clk_sys_i);
		grounded <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK(pin_en, 1'b1)
	endtask

	task automatic t_light();
		i_cpu.wr_reg(grpsc_pkg::ADDR_PS, grpsc_pkg::PS_LIGHT_CODE);
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK({dem, single}, 2'b11)
		i_cpu.rd_reg(grpsc_pkg::ADDR_PS, st);
		`CHK(st, grpsc_pkg::PS_LIGHT_CODE)
		i_cpu.wr_reg(grpsc_pkg::ADDR_PS, grpsc_pkg::PS_FULL_CODE);
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK({dem, single}, 2'b00)
	endtask

	task automatic t_vid();
		i_cpu.wr_reg(grpsc_pkg::ADDR_PS, grpsc_pkg::PS_LIGHT_CODE);
		i_cpu.wr_reg(grpsc_pkg::ADDR_VID, 8'hc0);
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK({dem, sink}, 2'b01)
		wait_dac(8'hc0);
		`CHK(pcf, 1'b1)
		i_cpu.rd_reg(grpsc_pkg::ADDR_STAT, st);
		`CHK({st[2], st[0]}, 2'b10)
		`CHK(dem, 1'b0)
		// boundary code: 8'hbf is not above the threshold
		i_cpu.light_after_vid(8'hbf);
		wait_dac(8'hbf);
		`CHK(pcf, 1'b0)
		`CHK(dem, 1'b1)
		i_cpu.wr_reg(grpsc_pkg::ADDR_PS, grpsc_pkg::PS_FULL_CODE);
	endtask

	task automatic t_offset();
		i_cpu.wr_reg(grpsc_pkg::ADDR_OFS, 8'h25);
		repeat (6) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK({ofs_add, ofs}, 9'h000)
		@(posedge clk_sys_i);
		sel_above <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK({ofs_add, ofs}, 9'h125)
		@(posedge clk_sys_i);
		sel_above <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK({ofs_add, ofs}, 9'h000)
	endtask

	task automatic t_disable();
		@(posedge clk_sys_i);
		rail_dis <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		i_cpu.wr_reg(grpsc_pkg::ADDR_PS, grpsc_pkg::PS_LIGHT_CODE);
		i_cpu.wr_reg(grpsc_pkg::ADDR_VID, 8'h40);
		i_cpu.rd_reg(grpsc_pkg::ADDR_STAT, st);
		`CHK(st & 8'h83, 8'h80)
		i_cpu.rd_reg(grpsc_pkg::ADDR_VID, st);
		`CHK(st, 8'hbf)
		i_cpu.wr_reg(grpsc_pkg::ADDR_STAT, 8'h80);
		rail_dis <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		i_cpu.rd_reg(grpsc_pkg::ADDR_STAT, st);
		`CHK(st & 8'h83, 8'h02)
		i_cpu.rd_reg(4'h9, st);
		`CHK(st, 8'h00)
	endtask

	// second power-up with the strap grounded: pin offset off, bus offset always added
	task automatic t_strap();
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK(pin_en, 1'b0)
		`CHK(sink, 1'b0)
		i_cpu.wr_reg(grpsc_pkg::ADDR_OFS, 8'h31);
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		`CHK({ofs_add, ofs}, 9'h131)
		i_cpu.wr_reg(grpsc_pkg::ADDR_PS, grpsc_pkg::PS_LIGHT_CODE);
		i_cpu.wr_reg(grpsc_pkg::ADDR_PS, 8'h03);
		i_cpu.rd_reg(grpsc_pkg::ADDR_STAT, st);
		`CHK(st & 8'h81, 8'h81)
		i_cpu.wr_reg(grpsc_pkg::ADDR_PS, grpsc_pkg::PS_FULL_CODE);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		arst_n_i  = 1'b0;
		rail_dis  = 1'b0;
		grounded  = 1'b0;
		sel_above = 1'b0;
		errors       = 0;
		total_checks = 0;
		repeat (8) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_light();
		t_vid();
		t_offset();
		t_disable();
		t_strap();
		end_sim();
	end

	initial begin
		repeat (40000) @(posedge clk_sys_i);
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
